// File: dbs_pkg.sv
// constants and carrier types for the dummy byte channel synchroniser
package dbs_pkg;
    // bus register byte offsets
    localparam logic [7:0] DBS_REG_CTRL    = 8'h00;
    localparam logic [7:0] DBS_REG_ANTDLY  = 8'h04;
    localparam logic [7:0] DBS_REG_STATUS  = 8'h08;
    localparam logic [7:0] DBS_REG_HDR     = 8'h0c;
    localparam logic [7:0] DBS_REG_STAMP   = 8'h10;
    localparam logic [7:0] DBS_REG_MAXDLY  = 8'h14;
    localparam logic [7:0] DBS_REG_PERIODS = 8'h18;
    localparam logic [7:0] DBS_REG_TRANSP  = 8'h1c;
    localparam logic [7:0] DBS_REG_TXDLY   = 8'h20;
    localparam logic [7:0] DBS_REG_RELEASE = 8'h24;
    localparam logic [7:0] DBS_REG_EMIT    = 8'h28;
    localparam logic [7:0] DBS_REG_ARRIVAL = 8'h2c;
    localparam logic [1:0] DBS_SEG_WINDOW  = 2'h1;     // addr[7:6]==1 -> segment bytes 0x40..0x7c
    // reset values
    localparam logic       DBS_CTRL_RST    = 1'b1;
    localparam logic [24:0] DBS_ANTDLY_RST = 25'h0;
    // segment layout, bit positions in the 128-bit segment
    localparam int DBS_SEG_BITS   = 128;
    localparam int DBS_MODE_POS   = 127;
    localparam int DBS_SUB_LSB    = 124;
    localparam int DBS_SLOT_LSB   = 120;
    localparam int DBS_STAMP_LSB  = 95;
    localparam int DBS_MAXDLY_LSB = 70;
    localparam int DBS_PER_LSB    = 38;
    localparam int DBS_RSV_LSB    = 8;
    localparam logic [29:0] DBS_RSV_VAL = 30'h3fffffff;
    // byte positions in the channel
    localparam logic [3:0] DBS_LAST_DATA   = 4'he;     // position 15, lsb not covered
    localparam logic [3:0] DBS_CHK_BYTE    = 4'hf;     // position 16 holds the checksum
    localparam logic [7:0] DBS_CHK_POLY    = 8'h97;
    localparam logic [3:0] DBS_FULL_BITS   = 4'h8;
    localparam logic [3:0] DBS_SHORT_BITS  = 4'h7;
    localparam logic [7:0] DBS_FILLER      = 8'haf;
    // one second in transport-stream bit periods
    localparam logic [26:0] DBS_SECOND_BITS = 27'd19392658;
    localparam int DBS_MOD_STEPS = 5;

    typedef enum logic [1:0] {
        DBS_IDLE    = 2'b00,
        DBS_COLLECT = 2'b01,
        DBS_CALC    = 2'b11
    } dbs_state_e;

    typedef struct packed {
        logic       valid;
        logic       dummy;    // byte sits in a dummy position
        logic [7:0] data;
    } dbs_byte_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } dbs_out_s;
endpackage

// File: dbs_seg_mem.sv
// two-bank store of the received segment bytes, registered read
`timescale 1ns/1ps
module dbs_seg_mem (
    input  wire logic       clk,
    input  wire logic       wrEn,
    input  wire logic [4:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic [4:0] rdAddr,
    output logic [7:0]      rdData
);
    logic [7:0] mem [32];

    // no reset on the array: contents are only meaningful once a bank is shown
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// File: dbs_sync_core.sv
// exciter side parser and timing engine for the dummy byte signaling channel
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - segment: mode, sub-frame, slot, stamp, max delay, periods, reserved ones, checksum
// RULE2 - sub-frame index from sender is 0 to 4
// RULE3 - slot index from sender spans 0 to 15
// RULE4 - sender keeps values equal to those in the control packet
// RULE5 - time stamp is bit periods from second tick to group release
// RULE6 - max delay is the system delay from sender output to emission
// RULE7 - 25-bit max delay equals joined 24-bit base and 1-bit extension
// RULE8 - period count is frame periods since epoch at emission
// RULE9 - checksum over first 119 bits, polynomial 0x97, checked here
// RULE10 - lsb of position fifteen carries nothing and is skipped
// RULE11 - sender puts stamp and max delay in every group
// RULE12 - measure group arrival in bit periods since last second tick
// RULE13 - transport delay is arrival minus stamp, plus one second if negative
// RULE14 - transmitter delay is max delay minus transport and antenna delay
// RULE15 - release to randomizer at stamp plus max delay minus antenna, mod second
// RULE16 - emission at stamp plus max delay, modulo one second
// RULE17 - transmitter delay is offered as the fifo depth guide
// RULE18 - sender output stays locked to broadcast system time
// RULE19 - bits packed msb first over bytes in transmission order
// RULE20 - channel is the 16 dummy positions of the first five packets
// RULE21 - every signaling dummy byte leaves as filler 0xaf; here only bytes of a segment whose group start came while enable_r was set are restored
// RULE22 - checksum msb first from zero; bad segment dropped and flagged
module dbs_sync_core (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire dbs_pkg::dbs_byte_s inByte,
    input  wire logic              groupStart,
    input  wire logic              gpsTick,
    input  wire logic              bitTick,
    output dbs_pkg::dbs_out_s      outByte,
    output logic                   releasePulse,
    output logic                   emitPulse,
    output logic [26:0]            fifoDepthHint,
    input  wire logic [7:0]        busAddr,
    input  wire logic [31:0]       busWdata,
    input  wire logic              busWr,
    input  wire logic              busRd,
    output logic [31:0]            busRdata
);
    import dbs_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // reduce a value below one second by bounded conditional subtraction
    function automatic logic [26:0] modSecond(input logic [26:0] v);
        logic [26:0] r;
        r = v;
        for (int i = 0; i < DBS_MOD_STEPS; i++) begin
            if (r >= DBS_SECOND_BITS) begin
                r = r - DBS_SECOND_BITS;
            end
        end
        return r;
    endfunction

    // advance the checksum over the top n bits of one byte, msb first
    function automatic logic [7:0] chkByte(input logic [7:0] c, input logic [7:0] d, input logic [3:0] n);
        logic [7:0] r;
        logic       fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (4'(7 - i) < n) begin
                fb = r[7] ^ d[i];
                r = {r[6:0], 1'b0};
                if (fb) begin
                    r = r ^ DBS_CHK_POLY;
                end
            end
        end
        return r;
    endfunction

    dbs_state_e         state_r;
    logic               enable_r;
    logic [24:0]        antDelay_r;
    logic [26:0]        bitCount_r;
    logic [24:0]        arrival_r;
    logic [3:0]         byteIdx_r;
    logic [7:0]         chk_r;
    logic [127:0]       seg_r;
    logic               chkErr_r;
    logic               segValid_r;
    logic [15:0]        errCount_r;
    logic [7:0]         header_r;
    logic [24:0]        stamp_r;
    logic [24:0]        maxDelay_r;
    logic [31:0]        periods_r;
    logic [24:0]        transport_r;
    logic [26:0]        txDelay_r;
    logic [26:0]        releaseAt_r;
    logic [26:0]        emitAt_r;
    logic               relArmed_r;
    logic               emitArmed_r;
    logic               wrBank_r;
    logic               showBank_r;
    logic [31:0]        rdReg_r;
    logic               rdMem_r;
    logic [7:0]         memQ;
    logic               sigByte;
    logic               lastByte;
    logic               chkGood;
    logic [127:0]       segNxt;
    logic [24:0]        stampNxt;
    logic [24:0]        maxDelayNxt;
    logic [24:0]        transportNxt;
    logic [26:0]        sumNxt;

    ////////////////////////////////////////////////////////////////////////////
    // second-tick time base and arrival capture
    ////////////////////////////////////////////////////////////////////////////

    // bit period counter restarts on every second tick and wraps at one second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bitCount_r <= '0;
        end else if (gpsTick) begin
            bitCount_r <= '0;
        end else if (bitTick) begin
            bitCount_r <= (bitCount_r == DBS_SECOND_BITS - 27'd1) ? 27'd0 : bitCount_r + 27'd1; // RULE12
        end
    end

    // arrival stamp is taken at the first sync bit of the group
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arrival_r <= '0;
        end else if (groupStart && enable_r) begin
            arrival_r <= bitCount_r[24:0]; // RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // segment collection and checksum
    ////////////////////////////////////////////////////////////////////////////

    assign sigByte  = inByte.valid && inByte.dummy && (state_r == DBS_COLLECT); // RULE20
    assign lastByte = sigByte && (byteIdx_r == DBS_CHK_BYTE);
    assign chkGood  = (inByte.data == chk_r);
    assign segNxt   = {seg_r[119:0], inByte.data}; // RULE19

    // a new group start restarts collection whenever enable_r is set, even mid-segment
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= DBS_IDLE;
        end else if (groupStart && enable_r) begin
            state_r <= DBS_COLLECT;
        end else begin
            unique case (state_r)
                DBS_IDLE: begin
                    state_r <= DBS_IDLE;
                end
                DBS_COLLECT: begin
                    if (lastByte) begin
                        state_r <= chkGood ? DBS_CALC : DBS_IDLE; // RULE22
                    end
                end
                DBS_CALC: begin
                    state_r <= DBS_IDLE;
                end
                default: begin
                    state_r <= DBS_IDLE;
                end
            endcase
        end
    end

    // byte index, shift register and running checksum from zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            byteIdx_r <= '0;
            chk_r     <= '0;
            seg_r     <= '0;
        end else if (groupStart && enable_r) begin
            byteIdx_r <= '0;
            chk_r     <= '0; // RULE22
        end else if (sigByte) begin
            byteIdx_r <= byteIdx_r + 4'd1;
            seg_r     <= segNxt; // RULE1
            if (byteIdx_r != DBS_CHK_BYTE) begin
                chk_r <= chkByte(chk_r, inByte.data,
                                 (byteIdx_r == DBS_LAST_DATA) ? DBS_SHORT_BITS : DBS_FULL_BITS); // RULE9 RULE10
            end
        end
    end

    // sticky error flag: a new failure in the clearing cycle wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chkErr_r   <= 1'b0;
            errCount_r <= '0;
        end else if (lastByte && !chkGood) begin
            chkErr_r   <= 1'b1; // RULE22
            errCount_r <= (errCount_r == 16'hffff) ? errCount_r : errCount_r + 16'd1;
        end else if (busWr && busAddr == DBS_REG_STATUS && busWdata[0]) begin
            chkErr_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // delay arithmetic on an accepted segment
    ////////////////////////////////////////////////////////////////////////////

    assign stampNxt     = seg_r[DBS_STAMP_LSB +: 25];
    assign maxDelayNxt  = seg_r[DBS_MAXDLY_LSB +: 25]; // RULE7
    assign transportNxt = (stampNxt > arrival_r)
                          ? 25'(27'(arrival_r) + DBS_SECOND_BITS - 27'(stampNxt))
                          : arrival_r - stampNxt; // RULE13
    assign sumNxt       = 27'(stampNxt) + 27'(maxDelayNxt);

    // fields and times only change after a good checksum, so a bad one is dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            header_r    <= '0;
            stamp_r     <= '0;
            maxDelay_r  <= '0;
            periods_r   <= '0;
            transport_r <= '0;
            txDelay_r   <= '0;
            releaseAt_r <= '0;
            emitAt_r    <= '0;
            segValid_r  <= 1'b0;
        end else if (state_r == DBS_CALC) begin
            header_r    <= seg_r[DBS_SLOT_LSB +: 8]; // RULE1
            stamp_r     <= stampNxt;
            maxDelay_r  <= maxDelayNxt;
            periods_r   <= seg_r[DBS_PER_LSB +: 32];
            transport_r <= transportNxt;
            txDelay_r   <= 27'(maxDelayNxt) - (27'(transportNxt) + 27'(antDelay_r)); // RULE14
            // two seconds added first so the antenna subtraction cannot go negative
            releaseAt_r <= modSecond(sumNxt + {DBS_SECOND_BITS[25:0], 1'b0} - 27'(antDelay_r)); // RULE15
            emitAt_r    <= modSecond(sumNxt); // RULE16
            segValid_r  <= 1'b1;
        end
    end

    assign fifoDepthHint = txDelay_r; // RULE17

    // instant pulses fire once per accepted segment when the time base matches
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            relArmed_r  <= 1'b0;
            emitArmed_r <= 1'b0;
        end else if (state_r == DBS_CALC) begin
            relArmed_r  <= 1'b1;
            emitArmed_r <= 1'b1;
        end else begin
            if (releasePulse) begin
                relArmed_r <= 1'b0;
            end
            if (emitPulse) begin
                emitArmed_r <= 1'b0;
            end
        end
    end

    assign releasePulse = relArmed_r && (bitCount_r == releaseAt_r); // RULE15
    assign emitPulse    = emitArmed_r && (bitCount_r == emitAt_r); // RULE16

    ////////////////////////////////////////////////////////////////////////////
    // byte pass-through with filler restore
    ////////////////////////////////////////////////////////////////////////////

    // one cycle of latency keeps the output off the combinational input path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            outByte <= '0;
        end else begin
            outByte.valid <= inByte.valid;
            outByte.data  <= sigByte ? DBS_FILLER : inByte.data; // RULE21
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // segment store and register port
    ////////////////////////////////////////////////////////////////////////////

    // the shown bank only flips on a good segment, so software never sees a bad one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrBank_r   <= 1'b0;
            showBank_r <= 1'b1;
        end else if (state_r == DBS_CALC) begin
            wrBank_r   <= ~wrBank_r;
            showBank_r <= wrBank_r;
        end
    end

    dbs_seg_mem u_mem (
        .clk    (clk),
        .wrEn   (sigByte),
        .wrAddr ({wrBank_r, byteIdx_r}),
        .wrData (inByte.data),
        .rdAddr ({showBank_r, busAddr[5:2]}),
        .rdData (memQ)
    );

    // writable control
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_r   <= DBS_CTRL_RST;
            antDelay_r <= DBS_ANTDLY_RST;
        end else if (busWr) begin
            if (busAddr == DBS_REG_CTRL) begin
                enable_r <= busWdata[0];
            end
            if (busAddr == DBS_REG_ANTDLY) begin
                antDelay_r <= busWdata[24:0];
            end
        end
    end

    // read data register; unmapped offsets read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdReg_r <= '0;
            rdMem_r <= 1'b0;
        end else begin
            rdMem_r <= busRd && (busAddr[7:6] == DBS_SEG_WINDOW);
            if (busRd) begin
                unique case (busAddr)
                    DBS_REG_CTRL:    rdReg_r <= {31'h0, enable_r};
                    DBS_REG_ANTDLY:  rdReg_r <= {7'h0, antDelay_r};
                    DBS_REG_STATUS:  rdReg_r <= {errCount_r, 14'h0, segValid_r, chkErr_r};
                    // mode comes from the latched header so a later bad segment cannot disturb it
                    DBS_REG_HDR:     rdReg_r <= {23'h0, header_r[7], 1'b0, header_r[6:0]};
                    DBS_REG_STAMP:   rdReg_r <= {7'h0, stamp_r};
                    DBS_REG_MAXDLY:  rdReg_r <= {7'h0, maxDelay_r};
                    DBS_REG_PERIODS: rdReg_r <= periods_r;
                    DBS_REG_TRANSP:  rdReg_r <= {7'h0, transport_r};
                    DBS_REG_TXDLY:   rdReg_r <= {5'h0, txDelay_r};
                    DBS_REG_RELEASE: rdReg_r <= {5'h0, releaseAt_r};
                    DBS_REG_EMIT:    rdReg_r <= {5'h0, emitAt_r};
                    DBS_REG_ARRIVAL: rdReg_r <= {7'h0, arrival_r};
                    default:         rdReg_r <= 32'h0;
                endcase
            end
        end
    end

    assign busRdata = rdMem_r ? {24'h0, memQ} : rdReg_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////////////

    property p_bad_flag;
        lastByte && !chkGood |=> chkErr_r && state_r == DBS_IDLE;
    endproperty
    a_bad_flag: assert property (p_bad_flag) else $error("bad checksum not flagged"); // RULE22

    property p_bad_drop;
        lastByte && !chkGood |=> ##1 $stable(stamp_r) && $stable(emitAt_r);
    endproperty
    a_bad_drop: assert property (p_bad_drop) else $error("bad segment changed results"); // RULE22

    property p_filler;
        sigByte |=> outByte.valid && outByte.data == 8'haf;
    endproperty
    a_filler: assert property (p_filler) else $error("signaling byte not restored"); // RULE21

    property p_arrival;
        groupStart && enable_r |=> arrival_r == $past(bitCount_r[24:0]);
    endproperty
    a_arrival: assert property (p_arrival) else $error("arrival not captured"); // RULE12

    property p_count_wrap;
        bitCount_r < DBS_SECOND_BITS;
    endproperty
    a_count_wrap: assert property (p_count_wrap) else $error("time base past one second"); // RULE12

    property p_transport;
        state_r == DBS_CALC |=> (27'(transport_r) + 27'(stamp_r)) == 27'(arrival_r)
            || (27'(transport_r) + 27'(stamp_r)) == 27'(arrival_r) + DBS_SECOND_BITS;
    endproperty
    a_transport: assert property (p_transport) else $error("transport delay wrong"); // RULE13

    property p_txdelay;
        state_r == DBS_CALC |=> txDelay_r + 27'(transport_r) + 27'(antDelay_r) == 27'(maxDelay_r);
    endproperty
    a_txdelay: assert property (p_txdelay) else $error("transmitter delay wrong"); // RULE14

    property p_emit;
        state_r == DBS_CALC |=> emitAt_r < DBS_SECOND_BITS
            && (emitAt_r == 27'(stamp_r) + 27'(maxDelay_r)
            || emitAt_r + DBS_SECOND_BITS == 27'(stamp_r) + 27'(maxDelay_r));
    endproperty
    a_emit: assert property (p_emit) else $error("emission instant wrong"); // RULE16

    property p_release;
        state_r == DBS_CALC |=> releaseAt_r < DBS_SECOND_BITS && emitPulse == 1'b0 ##0 relArmed_r;
    endproperty
    a_release: assert property (p_release) else $error("release instant not armed"); // RULE15
endmodule

// File: dbs_adapter_model.sv
// transmission adapter model: frames one signaling segment into dummy byte positions
`timescale 1ns/1ps
module dbs_adapter_model
    import dbs_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         send,
    input  wire logic         slow,
    input  wire logic         corrupt,
    input  wire logic [127:0] seg,
    output dbs_byte_s         inByte,
    output logic              groupStart,
    output logic              busy,
    output logic [7:0]        crc
);
    logic [127:0] frame;
    logic [4:0]   idx;
    logic         hold;
    // checksum msb first from zero; bit 8 is the spare lsb and stays outside it
    always_comb begin
        crc = 8'h00;
        for (int i = 127; i > 8; i--) begin
            crc = (crc[7] ^ seg[i]) ? ({crc[6:0], 1'b0} ^ DBS_CHK_POLY) : {crc[6:0], 1'b0};
        end
    end
    // group start first, then the 16 bytes; idle cycles show inverted data so stale bytes never match
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inByte <= '0;
            groupStart <= 1'b0;
            busy <= 1'b0;
            hold <= 1'b0;
        end else begin
            groupStart <= send;
            hold <= slow & ~hold;
            if (send) begin
                frame <= {seg[127:8], crc ^ {7'h0, corrupt}};
                idx <= 5'h0;
                busy <= 1'b1;
            end else if (busy && !groupStart && !hold) begin
                inByte <= '{valid: 1'b1, dummy: 1'b1, data: frame[8'd127 - 8 * idx -: 8]};
                idx <= idx + 5'h1;
                busy <= (idx != 5'hf);
            end else begin
                inByte <= '{valid: 1'b0, dummy: 1'b0, data: ~inByte.data};
            end
        end
    end
endmodule

// File: dbs_sync_core_bench.sv
// self-checking bench for the dummy byte channel synchroniser
`timescale 1ns/1ps
module dbs_sync_core_bench;
    import dbs_pkg::*;
    logic         clk = 0, reset_n = 0, gpsTick = 0, bitTick = 1, send = 0, slow = 0, corrupt = 0;
    logic         busWr = 0, busRd = 0, groupStart, busy, releasePulse, emitPulse;
    logic [7:0]   busAddr = 0, crc;
    logic [31:0]  busWdata = 0, busRdata, arr, lastSt;
    logic [26:0]  bc, fifoDepthHint;
    logic [127:0] seg = 0;
    dbs_byte_s    inByte;
    dbs_out_s     outByte;
    int           failCount = 0, checked = 0, cyc = 0;
    dbs_adapter_model i_tam (.clk(clk), .reset_n(reset_n), .send(send), .slow(slow), .corrupt(corrupt),
        .seg(seg), .inByte(inByte), .groupStart(groupStart), .busy(busy), .crc(crc));
    dbs_sync_core i_dut (.clk(clk), .reset_n(reset_n), .inByte(inByte), .groupStart(groupStart),
        .gpsTick(gpsTick), .bitTick(bitTick), .outByte(outByte), .releasePulse(releasePulse),
        .emitPulse(emitPulse), .fifoDepthHint(fifoDepthHint), .busAddr(busAddr), .busWdata(busWdata),
        .busWr(busWr), .busRd(busRd), .busRdata(busRdata));
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    // own bit counter: zeroed by the second tick, so arrival is known without the design
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bc <= '0;
        end else begin
            bc <= gpsTick ? 27'h0 : bc + {26'h0, bitTick};
            if (groupStart) arr <= {5'h0, bc};
        end
    end
    // every signaling byte must leave as filler
    always @(negedge clk) begin
        if (outByte.valid) cmp("out byte", 32'haf, {24'h0, outByte.data});
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failCount++;
            finishTest();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busWr <= 1'b1;
        busAddr <= a;
        busWdata <= d;
        @(posedge clk);
        busWr <= 1'b0;
    endtask
    // segment window read data stand only in the cycle after the strobe; register read data hold until the next read
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        busRd <= 1'b1;
        busAddr <= a;
        @(posedge clk);
        busRd <= 1'b0;
        @(negedge clk);
        cmp(n, e & m, busRdata & m);
    endtask
    // reset values, antenna delay access, unmapped offset
    task automatic t_regs();
        rd("enable", DBS_REG_CTRL, 32'h1, 32'h1);
        wr(DBS_REG_CTRL, 32'h0);
        rd("enable off", DBS_REG_CTRL, 32'h0, 32'h1);
        wr(DBS_REG_CTRL, 32'h1);
        rd("antenna", DBS_REG_ANTDLY, 32'h0, 32'hffffffff);
        wr(8'h30, 32'h5a5a5a5a);
        rd("unmapped", 8'h30, 32'h0, 32'hffffffff);
        wr(DBS_REG_ANTDLY, 32'd20);
        rd("antenna", DBS_REG_ANTDLY, 32'd20, 32'hffffffff);
    endtask
    // one group: stamp, max delay, header fields; a bad checksum must leave results alone
    task automatic t_seg(input logic [24:0] st, input logic [24:0] md, input logic [7:0] h, input logic sl,
                         input logic bad);
        logic [31:0] tr, tx, rl, em, rs, es;
        seg = {h, st, md, 32'hcafe0001, 30'h3fffffff, 8'h0};
        @(posedge clk);
        gpsTick <= 1'b1;
        @(posedge clk);
        gpsTick <= 1'b0;
        repeat (40) @(posedge clk);
        slow <= sl;
        corrupt <= bad;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (4) @(posedge clk);
        if (bad) begin
            rd("status", DBS_REG_STATUS, 32'h00010001, 32'hffff0001);
            rd("stamp kept", DBS_REG_STAMP, lastSt, 32'hffffffff);
            wr(DBS_REG_STATUS, 32'h1);
            rd("status clr", DBS_REG_STATUS, 32'h00010000, 32'hffff0001);
        end else begin
            lastSt = {7'h0, st};
            tr = (st > arr) ? arr + DBS_SECOND_BITS - st : arr - st;
            tx = (md - (tr + 32'd20)) & 32'h7ffffff;
            rl = (st + md - 32'd20) % DBS_SECOND_BITS;
            em = (st + md) % DBS_SECOND_BITS;
            rd("valid", DBS_REG_STATUS, 32'h2, 32'h2);
            rd("header", DBS_REG_HDR, {23'h0, h[7], 1'b0, h[6:0]}, 32'h1ff);
            rd("stamp", DBS_REG_STAMP, st, 32'hffffffff);
            rd("max delay", DBS_REG_MAXDLY, md, 32'hffffffff);
            rd("periods", DBS_REG_PERIODS, 32'hcafe0001, 32'hffffffff);
            rd("arrival", DBS_REG_ARRIVAL, arr, 32'hffffffff);
            rd("transport", DBS_REG_TRANSP, tr, 32'hffffffff);
            rd("tx delay", DBS_REG_TXDLY, tx, 32'h7ffffff);
            rd("release", DBS_REG_RELEASE, rl, 32'hffffffff);
            rd("emission", DBS_REG_EMIT, em, 32'hffffffff);
            rd("byte0", 8'h40, seg[127:120], 32'hff);
            rd("checksum", 8'h7c, crc, 32'hff);
            cmp("depth hint", tx, {5'h0, fifoDepthHint});
            rs = 0;
            es = 0;
            repeat (400) begin
                @(negedge clk);
                if (releasePulse) rs = {5'h0, bc};
                if (emitPulse) es = {5'h0, bc};
            end
            cmp("release at", rl, rs);
            cmp("emit at", em, es);
        end
    endtask
    task automatic finishTest();
        $display("checks %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_seg(25'd10, 25'd300, 8'hcf, 1'b1, 1'b0);
        t_seg(25'd19392600, 25'd250, 8'h00, 1'b0, 1'b0);
        t_seg(25'd77, 25'd500, 8'ha3, 1'b0, 1'b1);
        finishTest();
    end
endmodule
